// File: core/srg_pkg.sv
package srg_pkg;
   localparam int CLK_PERIOD_NS = 20;
   localparam int DEBOUNCE_NS = 250;
   localparam int DEB_CYC = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OFF_LAT_NS = 60;
   localparam int OFF_LAT_CYC = OFF_LAT_NS / CLK_PERIOD_NS;
   localparam int PCT_FULL = 100;
   localparam int ENTRY_PCT = 40;
   localparam int EXIT_PCT = 60;
   localparam int ENTRY_CYCLES = 16;
   localparam int EXIT_CYCLES = 8;
   localparam int IGN_ENTER = 128;
   localparam int IGN_EXIT = 256;
   localparam int REV_CYCLES = 2;
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_STAT = 8'h04;
   localparam logic [7:0] A_CYC = 8'h08;
   localparam logic [7:0] A_CON = 8'h0c;
   localparam int CTRL_EN = 0;
   localparam int CTRL_NOSLEEP = 1;
   localparam logic [1:0] CTRL_RST = 2'h1;
   localparam int ST_GATE_A = 0;
   localparam int ST_GATE_B = 1;
   localparam int ST_SLEEP = 2;
   localparam int ST_THR = 3;
   localparam int ST_IGN = 4;
   localparam int ST_REVLOCK = 5;
   localparam int ST_RUN = 6;
   typedef enum logic [4:0] {
      CH_IDLE = 5'h01,
      CH_PRE = 5'h02,
      CH_QUAL = 5'h04,
      CH_ON = 5'h08,
      CH_DONE = 5'h10
   } srg_ch_e;
endpackage

// File: core/srg_ctrl.sv
// Behaviour
// - two interlocked channel machines, never both on
// - own rise above arm level arms opposite
// - fall below pre-trigger level pre-triggers channel
// - turn-off level one of two, both channels
// - sense-detect crossing starts on-detection qualification
// - turn on only after debounce time held
// - turn-off level checked only in second half
// - first half: only reversal comparison turns off
// - turn-off reaches gate within latency limit
// - turn on only while opposite was armed
// - one switching per cycle, wait for opposite
// - missed turn-on skips other channel next cycle
// - cycle timed from pre-trigger and arm edges
// - conduction timed until gate off or release
// - sleep after 16 short-conduction cycles, one channel
// - no gate drive while asleep
// - wake after 8 long-conduction cycles, both channels
// - ignore 128 cycles after entry, 256 after exit
// - after ignore, switch at once if met
// - gates work only while enable is high
// - level choice latched at supply start, held
// - two reversal cycles force sleep
//
// Added by the designer: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ns
module srg_ctrl #(
   parameter int CNT_W = 16
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic supply_ok,
   input wire logic en_above,
   input wire logic thr_sel_low,
   input wire logic drain_sense_a_arm,
   input wire logic drain_sense_a_pt,
   input wire logic drain_sense_a_on,
   input wire logic drain_sense_a_off12,
   input wire logic drain_sense_a_off25,
   input wire logic drain_sense_a_rev,
   input wire logic drain_sense_b_arm,
   input wire logic drain_sense_b_pt,
   input wire logic drain_sense_b_on,
   input wire logic drain_sense_b_off12,
   input wire logic drain_sense_b_off25,
   input wire logic drain_sense_b_rev,
   output logic gate_out_a,
   output logic gate_out_b,
   output logic sleep_active
);
   localparam int DW = $clog2(srg_pkg::DEB_CYC + 1);
   localparam int EW = $clog2(srg_pkg::ENTRY_CYCLES + 1);
   localparam int IW = $clog2(srg_pkg::IGN_EXIT + 1);
   localparam int PW = CNT_W + 7;
   localparam int NS = 15;

   // Comparator outputs are asynchronous to hclk, so all of them pass two flops.
   logic [NS-1:0] raw;
   logic [NS-1:0] s1_q;
   logic [NS-1:0] s2_q;
   logic [11:0] prev_q;
   assign raw = {supply_ok, en_above, thr_sel_low,
                 drain_sense_b_rev, drain_sense_b_off25, drain_sense_b_off12,
                 drain_sense_b_on, drain_sense_b_pt, drain_sense_b_arm,
                 drain_sense_a_rev, drain_sense_a_off25, drain_sense_a_off12,
                 drain_sense_a_on, drain_sense_a_pt, drain_sense_a_arm};

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_q <= '0;
         s2_q <= '0;
         prev_q <= '0;
      end else begin
         s1_q <= raw;
         s2_q <= s1_q;
         prev_q <= s2_q[11:0];
      end
   end

   logic [5:0] cs [2];
   logic [5:0] cp [2];
   logic arm_rise [2];
   logic pt_fall [2];
   logic on_rise [2];
   logic gate_q [2];
   logic arm_q [2];
   logic fail_q [2];
   logic go [2];
   logic [CNT_W-1:0] cyc_prev_q [2];
   logic [CNT_W-1:0] con_prev_q [2];
   logic [EW-1:0] ent_q [2];
   logic [EW-1:0] ex_q [2];
   logic [1:0] rev_cnt_q [2];

   logic supply_s;
   logic clr;
   logic run;
   logic drive_ok;
   logic sleep_q;
   logic rev_lock_q;
   logic [IW-1:0] ign_q;
   logic thr_q;
   logic ok_d_q;
   logic [1:0] ctrl_q;
   logic rev_trip;

   assign cs[0] = s2_q[5:0];
   assign cs[1] = s2_q[11:6];
   assign cp[0] = prev_q[5:0];
   assign cp[1] = prev_q[11:6];
   assign supply_s = s2_q[14];
   assign clr = !supply_s;
   assign run = s2_q[13] && ctrl_q[srg_pkg::CTRL_EN] && supply_s;
   assign drive_ok = run && !sleep_q;

   // The threshold choice is frozen for the whole powered interval.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ok_d_q <= 1'b0;
         thr_q <= 1'b0;
      end else begin
         ok_d_q <= supply_s;
         if (supply_s && !ok_d_q) begin
            thr_q <= s2_q[12];
         end
      end
   end

   genvar i;
   for (i = 0; i < 2; i++) begin : g_ch
      localparam int J = 1 - i;
      srg_pkg::srg_ch_e st_q;
      logic [DW-1:0] deb_q;
      logic [CNT_W-1:0] cyc_q;
      logic [CNT_W-1:0] con_q;
      logic con_run_q;
      logic con_seen_q;
      logic rev_seen_q;
      logic went_q;
      logic first_half;
      logic off_hit;
      logic off_now;
      logic grant;
      logic [PW-1:0] con_p;
      logic [PW-1:0] cyc_lo;
      logic [PW-1:0] cyc_hi;

      // The synchroniser resets low while idle drains sit high, so edges wait one cycle
      // after supply is seen; otherwise every channel would see a false arm edge.
      assign arm_rise[i] = cs[i][0] && !cp[i][0] && ok_d_q;
      assign pt_fall[i] = !cs[i][1] && cp[i][1] && ok_d_q;
      assign on_rise[i] = cs[i][2] && !cp[i][2] && ok_d_q;
      assign first_half = con_q < (cyc_prev_q[i] >> 1);
      assign off_hit = thr_q ? cs[i][4] : cs[i][3];
      assign off_now = !drive_ok || (first_half ? cs[i][5] : off_hit);
      assign go[i] = st_q == srg_pkg::CH_QUAL && cs[i][2] && !arm_rise[i]
                     && deb_q >= DW'(srg_pkg::DEB_CYC) && drive_ok
                     && arm_q[i] && !gate_q[J] && !fail_q[J];
      // Channel a wins a same-cycle tie so both gates can never rise together.
      assign grant = go[i] && !(go[J] && (J == 0));

      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            st_q <= srg_pkg::CH_IDLE;
            gate_q[i] <= 1'b0;
            deb_q <= '0;
         end else if (clr || !run) begin
            st_q <= srg_pkg::CH_IDLE;
            gate_q[i] <= 1'b0;
            deb_q <= '0;
         end else begin
            case (st_q)
               srg_pkg::CH_IDLE: begin
                  if (pt_fall[i]) begin
                     st_q <= srg_pkg::CH_PRE;
                  end
               end
               srg_pkg::CH_PRE: begin
                  if (arm_rise[i]) begin
                     st_q <= srg_pkg::CH_IDLE;
                  end else if (cs[i][2]) begin
                     st_q <= srg_pkg::CH_QUAL;
                     deb_q <= DW'(1);
                  end
               end
               srg_pkg::CH_QUAL: begin
                  if (arm_rise[i]) begin
                     st_q <= srg_pkg::CH_IDLE;
                  end else if (!cs[i][2]) begin
                     st_q <= srg_pkg::CH_PRE;
                  end else if (grant) begin
                     st_q <= srg_pkg::CH_ON;
                     gate_q[i] <= 1'b1;
                  end else if (deb_q >= DW'(srg_pkg::DEB_CYC)) begin
                     st_q <= srg_pkg::CH_DONE;
                  end else begin
                     deb_q <= deb_q + DW'(1);
                  end
               end
               srg_pkg::CH_ON: begin
                  // Off decision is registered straight onto the gate flop.
                  if (off_now) begin
                     st_q <= srg_pkg::CH_DONE;
                     gate_q[i] <= 1'b0;
                  end
               end
               srg_pkg::CH_DONE: begin
                  // The opposite drain rising and this drain falling often share an edge.
                  if (arm_rise[J] && pt_fall[i]) begin
                     st_q <= srg_pkg::CH_PRE;
                  end else if (arm_rise[J]) begin
                     st_q <= srg_pkg::CH_IDLE;
                  end
               end
               default: begin
                  st_q <= srg_pkg::CH_IDLE;
                  gate_q[i] <= 1'b0;
               end
            endcase
         end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            arm_q[i] <= 1'b0;
         end else if (clr) begin
            arm_q[i] <= 1'b0;
         end else if (arm_rise[J]) begin
            arm_q[i] <= 1'b1;
         end else if (arm_rise[i] || (gate_q[i] && off_now)) begin
            arm_q[i] <= 1'b0;
         end
      end

      assign con_p = PW'(con_q) * PW'(srg_pkg::PCT_FULL);
      assign cyc_lo = PW'(cyc_q) * PW'(srg_pkg::ENTRY_PCT);
      assign cyc_hi = PW'(cyc_q) * PW'(srg_pkg::EXIT_PCT);

      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            cyc_q <= '0;
            con_q <= '0;
            con_run_q <= 1'b0;
            con_seen_q <= 1'b0;
            rev_seen_q <= 1'b0;
            went_q <= 1'b0;
            cyc_prev_q[i] <= '0;
            con_prev_q[i] <= '0;
            ent_q[i] <= '0;
            ex_q[i] <= '0;
            rev_cnt_q[i] <= '0;
            fail_q[i] <= 1'b0;
         end else if (clr) begin
            cyc_q <= '0;
            con_q <= '0;
            con_run_q <= 1'b0;
            con_seen_q <= 1'b0;
            rev_seen_q <= 1'b0;
            went_q <= 1'b0;
            cyc_prev_q[i] <= '0;
            con_prev_q[i] <= '0;
            ent_q[i] <= '0;
            ex_q[i] <= '0;
            rev_cnt_q[i] <= '0;
            fail_q[i] <= 1'b0;
         end else begin
            if (pt_fall[i]) begin
               cyc_q <= '0;
            end else if (cyc_q != '1) begin
               cyc_q <= cyc_q + CNT_W'(1);
            end
            if (arm_rise[i]) begin
               // Cycle end: judge this cycle, then start afresh.
               cyc_prev_q[i] <= cyc_q;
               con_prev_q[i] <= con_q;
               con_q <= '0;
               con_run_q <= 1'b0;
               con_seen_q <= 1'b0;
               if (con_p < cyc_lo) begin
                  if (ent_q[i] != EW'(srg_pkg::ENTRY_CYCLES)) begin
                     ent_q[i] <= ent_q[i] + EW'(1);
                  end
               end else begin
                  ent_q[i] <= '0;
               end
               if (con_p > cyc_hi) begin
                  if (ex_q[i] != EW'(srg_pkg::EXIT_CYCLES)) begin
                     ex_q[i] <= ex_q[i] + EW'(1);
                  end
               end else begin
                  ex_q[i] <= '0;
               end
               if (rev_seen_q) begin
                  if (rev_cnt_q[i] != 2'(srg_pkg::REV_CYCLES)) begin
                     rev_cnt_q[i] <= rev_cnt_q[i] + 2'h1;
                  end
               end else begin
                  rev_cnt_q[i] <= '0;
               end
               rev_seen_q <= 1'b0;
               // A skipped channel does not count as a miss, or both would skip forever.
               fail_q[i] <= !went_q && !fail_q[J] && drive_ok;
               went_q <= 1'b0;
            end else begin
               if (on_rise[i] && !con_seen_q) begin
                  con_run_q <= 1'b1;
                  con_seen_q <= 1'b1;
               end else if (con_run_q && ((gate_q[i] && off_now)
                            || (!cs[i][2] && st_q != srg_pkg::CH_ON))) begin
                  con_run_q <= 1'b0;
               end
               if (con_run_q && con_q != '1) begin
                  con_q <= con_q + CNT_W'(1);
               end
               if (grant) begin
                  went_q <= 1'b1;
               end
               if (st_q == srg_pkg::CH_ON && first_half && cs[i][5]) begin
                  rev_seen_q <= 1'b1;
               end
            end
         end
      end
   end

   assign rev_trip = rev_cnt_q[0] == 2'(srg_pkg::REV_CYCLES)
                     || rev_cnt_q[1] == 2'(srg_pkg::REV_CYCLES);

   // Channel a arm edges mark converter periods for the ignore window.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sleep_q <= 1'b0;
         ign_q <= '0;
         rev_lock_q <= 1'b0;
      end else if (clr) begin
         sleep_q <= 1'b0;
         ign_q <= '0;
         rev_lock_q <= 1'b0;
      end else if (!sleep_q && (rev_trip || (ign_q == '0 && !ctrl_q[srg_pkg::CTRL_NOSLEEP]
                   && (ent_q[0] == EW'(srg_pkg::ENTRY_CYCLES)
                   || ent_q[1] == EW'(srg_pkg::ENTRY_CYCLES))))) begin
         sleep_q <= 1'b1;
         ign_q <= IW'(srg_pkg::IGN_ENTER);
         rev_lock_q <= rev_trip;
      end else if (sleep_q && ign_q == '0 && ex_q[0] == EW'(srg_pkg::EXIT_CYCLES)
                   && ex_q[1] == EW'(srg_pkg::EXIT_CYCLES)) begin
         sleep_q <= 1'b0;
         ign_q <= IW'(srg_pkg::IGN_EXIT);
         rev_lock_q <= 1'b0;
      end else if (arm_rise[0] && ign_q != '0) begin
         ign_q <= ign_q - IW'(1);
      end
   end

   // AHB-Lite slave: zero wait states, always OKAY.
   logic wr_q;
   logic [7:0] addr_q;
   logic [31:0] rd_d;
   logic [31:0] stat;
   logic [31:0] hrdata_q;
   logic hreadyout_q;
   logic hresp_q;

   always_comb begin
      stat = '0;
      stat[srg_pkg::ST_GATE_A] = gate_q[0];
      stat[srg_pkg::ST_GATE_B] = gate_q[1];
      stat[srg_pkg::ST_SLEEP] = sleep_q;
      stat[srg_pkg::ST_THR] = thr_q;
      stat[srg_pkg::ST_IGN] = ign_q != '0;
      stat[srg_pkg::ST_REVLOCK] = rev_lock_q;
      stat[srg_pkg::ST_RUN] = run;
      case (haddr[7:0])
         srg_pkg::A_CTRL: rd_d = {30'h0, ctrl_q};
         srg_pkg::A_STAT: rd_d = stat;
         srg_pkg::A_CYC: rd_d = {16'(cyc_prev_q[1]), 16'(cyc_prev_q[0])};
         srg_pkg::A_CON: rd_d = {16'(con_prev_q[1]), 16'(con_prev_q[0])};
         default: rd_d = '0;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
         addr_q <= '0;
         hrdata_q <= '0;
         hreadyout_q <= 1'b1;
         hresp_q <= 1'b0;
      end else if (hready) begin
         wr_q <= hsel && htrans[1] && hwrite;
         addr_q <= haddr[7:0];
         if (hsel && htrans[1] && !hwrite) begin
            hrdata_q <= rd_d;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= srg_pkg::CTRL_RST;
      end else if (wr_q && addr_q == srg_pkg::A_CTRL) begin
         ctrl_q <= hwdata[1:0];
      end
   end

   assign hrdata = hrdata_q;
   assign hreadyout = hreadyout_q;
   assign hresp = hresp_q;
   assign gate_out_a = gate_q[0];
   assign gate_out_b = gate_q[1];
   assign sleep_active = sleep_q;

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_interlock;
      !(gate_out_a && gate_out_b);
   endproperty
   a_interlock: assert property (p_interlock) else $error("both gates on");
   property p_arm_set;
      arm_rise[1] && supply_s |=> arm_q[0];
   endproperty
   a_arm_set: assert property (p_arm_set) else $error("channel not armed");
   property p_pre;
      pt_fall[0] && run && g_ch[0].st_q == srg_pkg::CH_IDLE |=> g_ch[0].st_q == srg_pkg::CH_PRE;
   endproperty
   a_pre: assert property (p_pre) else $error("pre-trigger missed");
   property p_deb;
      $rose(gate_out_a) |-> $past(cs[0][2], 1) && $past(cs[0][2], 13) && $past(arm_q[0]);
   endproperty
   a_deb: assert property (p_deb) else $error("turn-on without debounce");
   property p_first_half;
      gate_q[0] && g_ch[0].first_half && !cs[0][5] && drive_ok |=> gate_q[0];
   endproperty
   a_first_half: assert property (p_first_half) else $error("early turn-off");
   property p_lat;
      gate_q[0] && !g_ch[0].first_half && g_ch[0].off_hit |=> !gate_q[0];
   endproperty
   a_lat: assert property (p_lat) else $error("turn-off late");
   property p_once;
      $fell(gate_q[0]) && $past(run) |-> g_ch[0].st_q == srg_pkg::CH_DONE;
   endproperty
   a_once: assert property (p_once) else $error("second switching");
   property p_skip;
      $rose(gate_q[1]) |-> !$past(fail_q[0]);
   endproperty
   a_skip: assert property (p_skip) else $error("unbalanced turn-on");
   property p_sleep_off;
      sleep_q |=> !gate_q[0] && !gate_q[1];
   endproperty
   a_sleep_off: assert property (p_sleep_off) else $error("gate on in sleep");
   property p_ign;
      $rose(sleep_q) |-> ign_q == IW'(srg_pkg::IGN_ENTER);
   endproperty
   a_ign: assert property (p_ign) else $error("entry ignore count wrong");
   property p_en;
      !s2_q[13] |=> !gate_out_a && !gate_out_b;
   endproperty
   a_en: assert property (p_en) else $error("gate on while disabled");
   property p_thr;
      ok_d_q && supply_s |=> $stable(thr_q);
   endproperty
   a_thr: assert property (p_thr) else $error("threshold changed");
   property p_rev;
      rev_trip && !sleep_q && supply_s |=> sleep_q;
   endproperty
   a_rev: assert property (p_rev) else $error("reversal not handled");

   c_gate: cover property ($rose(gate_q[0]) ##[1:1000] $rose(gate_q[1]));
   c_sleep: cover property ($rose(sleep_q));
   c_wake: cover property ($fell(sleep_q) && supply_s);
   c_rev: cover property (rev_trip);
endmodule

// File: bench/srg_fet_model.sv
`timescale 1ns/1ns
// One half of the centre tap: each go opens a window of h cycles with diode
// conduction for con cycles; outside the window the drain sits high.
module srg_fet_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic go,
   input wire logic [7:0] h,
   input wire logic [7:0] con,
   output logic arm,
   output logic pt,
   output logic on,
   output logic off12,
   output logic off25,
   output logic rev
);
   logic act_q;
   logic [7:0] t_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         act_q <= 1'b0;
         t_q <= 8'h00;
      end else if (go) begin
         act_q <= 1'b1;
         t_q <= 8'h00;
      end else if (act_q) begin
         t_q <= t_q + 8'h01;
         if (t_q == h - 8'h01) begin
            act_q <= 1'b0;
         end
      end
   end
   assign arm = !act_q;
   assign pt = !act_q;
   assign on = act_q && t_q >= 8'h02 && t_q <= con + 8'h01;
   // The current tails off over two cycles, so the -25 mV level trips first.
   assign off25 = !on || t_q >= con;
   assign off12 = !on || t_q == con + 8'h01;
   assign rev = !on;
endmodule

// File: bench/sync_rect_gate_control_tb.sv
`timescale 1ns/1ns
module sync_rect_gate_control_tb;
   localparam logic [7:0] H = 8'h32;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic supply_ok, en_above, thr_sel_low, go_a, go_b, ga_q, gb_q;
   logic [7:0] con_a, con_b;
   logic aa, ap, ao, a12, a25, ar, ba, bp, bo, b12, b25, br, gate_out_a, gate_out_b, sleep_active;
   int failures, n_checks, rise_a, rise_b, both, lat, lat_max;
   assign hready = hreadyout;
   srg_ctrl uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .supply_ok(supply_ok), .en_above(en_above),
      .thr_sel_low(thr_sel_low), .drain_sense_a_arm(aa), .drain_sense_a_pt(ap),
      .drain_sense_a_on(ao), .drain_sense_a_off12(a12), .drain_sense_a_off25(a25),
      .drain_sense_a_rev(ar), .drain_sense_b_arm(ba), .drain_sense_b_pt(bp),
      .drain_sense_b_on(bo), .drain_sense_b_off12(b12), .drain_sense_b_off25(b25),
      .drain_sense_b_rev(br), .gate_out_a(gate_out_a), .gate_out_b(gate_out_b),
      .sleep_active(sleep_active));
   srg_fet_model fa (.clk(hclk), .rst_n(hresetn), .go(go_a), .h(H), .con(con_a), .arm(aa),
      .pt(ap), .on(ao), .off12(a12), .off25(a25), .rev(ar));
   srg_fet_model fb (.clk(hclk), .rst_n(hresetn), .go(go_b), .h(H), .con(con_b), .arm(ba),
      .pt(bp), .on(bo), .off12(b12), .off25(b25), .rev(br));
   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      ga_q <= gate_out_a;
      gb_q <= gate_out_b;
      if (gate_out_a && !ga_q) rise_a++;
      if (gate_out_b && !gb_q) rise_b++;
      if (gate_out_a && gate_out_b) both++;
      lat = (a12 && gate_out_a) ? lat + 1 : 0;
      if (lat > lat_max) lat_max = lat;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic period(input int n, input logic [7:0] ca, input logic [7:0] cb);
      rise_a = 0;
      rise_b = 0;
      repeat (n) begin
         con_a <= ca;
         con_b <= cb;
         go_a <= 1'b1;
         @(posedge hclk) go_a <= 1'b0;
         repeat (H - 1) @(posedge hclk);
         go_b <= 1'b1;
         @(posedge hclk) go_b <= 1'b0;
         repeat (H - 1) @(posedge hclk);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic t_regs();
      chk(hresp, 1'b0, "hresp");
      bus(1'b0, srg_pkg::A_CTRL, 32'h0);
      chk(rd, 32'h1, "ctrl reset");
      bus(1'b0, srg_pkg::A_STAT, 32'h0);
      chk(rd & 32'hf, 32'h0, "stat reset");
      bus(1'b0, 8'h40, 32'h0);
      chk(rd, 32'h0, "unmapped read");
      bus(1'b1, srg_pkg::A_CTRL, 32'h3);
      bus(1'b0, srg_pkg::A_CTRL, 32'h0);
      chk(rd, 32'h3, "ctrl readback");
      bus(1'b1, srg_pkg::A_CTRL, 32'h1);
      $display("test regs done");
   endtask
   task automatic t_switch();
      period(2, 8'h28, 8'h28);
      both = 0;
      lat_max = 0;
      period(8, 8'h28, 8'h28);
      chk(32'(rise_a >= 6 && rise_a <= 8), 32'h1, "gate a pulses");
      chk(32'(rise_b >= 6 && rise_b <= 8), 32'h1, "gate b pulses");
      chk(32'(both), 32'h0, "both gates on");
      chk(32'(lat_max <= srg_pkg::OFF_LAT_CYC), 32'h1, "turn-off latency");
      bus(1'b0, srg_pkg::A_CYC, 32'h0);
      chk(32'(rd[15:0] >= H - 8'h02 && rd[15:0] <= H), 32'h1, "cycle a");
      chk(32'(rd[31:16] >= H - 8'h02 && rd[31:16] <= H), 32'h1, "cycle b");
      bus(1'b0, srg_pkg::A_CON, 32'h0);
      chk(32'(rd[15:0] >= 8'h25 && rd[15:0] <= 8'h29), 32'h1, "conduction a");
      $display("test switch done");
   endtask
   task automatic t_deb_en();
      period(1, 8'h0a, 8'h28);
      chk(32'(rise_a), 32'h0, "short on-pulse");
      chk(32'(rise_b), 32'h0, "balanced skip");
      period(3, 8'h28, 8'h28);
      en_above <= 1'b0;
      period(3, 8'h28, 8'h28);
      chk(32'(rise_a + rise_b), 32'h0, "gates while disabled");
      en_above <= 1'b1;
      $display("test debounce enable done");
   endtask
   task automatic t_sleep();
      period(20, 8'h0c, 8'h0c);
      chk(sleep_active, 1'b1, "sleep entry");
      period(100, 8'h28, 8'h28);
      chk(sleep_active, 1'b1, "exit held off");
      chk(32'(rise_a + rise_b), 32'h0, "gates in sleep");
      period(40, 8'h28, 8'h28);
      chk(sleep_active, 1'b0, "sleep exit");
      period(3, 8'h14, 8'h14);
      chk(sleep_active, 1'b1, "reversal sleep");
      bus(1'b0, srg_pkg::A_STAT, 32'h0);
      chk(rd[srg_pkg::ST_REVLOCK], 1'b1, "reversal lock");
      thr_sel_low <= 1'b1;
      supply_ok <= 1'b0;
      repeat (5) @(posedge hclk);
      supply_ok <= 1'b1;
      repeat (5) @(posedge hclk);
      thr_sel_low <= 1'b0;
      repeat (5) @(posedge hclk);
      bus(1'b0, srg_pkg::A_STAT, 32'h0);
      chk(rd[srg_pkg::ST_THR], 1'b1, "level held");
      chk(rd[srg_pkg::ST_SLEEP], 1'b0, "sleep cleared by undervoltage");
      $display("test sleep done");
   endtask
   initial begin
      hresetn = 1'b0;
      {hsel, hwrite, go_a, go_b, thr_sel_low} = '0;
      {supply_ok, en_above} = 2'h3;
      {haddr, hwdata, htrans, hsize, con_a, con_b} = '0;
      {failures, n_checks, rise_a, rise_b, both, lat, lat_max} = '0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      hsize <= 3'h2;
      @(posedge hclk);
      t_regs();
      t_switch();
      t_deb_en();
      t_sleep();
      end_sim();
   end
   initial begin
      repeat (60000) @(posedge hclk);
      failures++;
      end_sim();
   end
endmodule
